// >>> rtl/ces_clk_pkg.sv
package ces_clk_pkg;
    // Avalon slave geometry
    localparam int AVS_AW = 5;
    localparam int AVS_DW = 32;
    // Register byte offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_THRESH = 5'h04;
    localparam logic [4:0] REG_STATUS = 5'h08;
    localparam logic [4:0] REG_INC = 5'h0C;
    localparam logic [4:0] REG_RTS = 5'h10;
    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CHAN_BIT = 2;
    localparam int CTRL_ALT_BIT = 3;
    localparam int THR_LO_LSB = 0;
    localparam int THR_HI_LSB = 8;
    localparam int STAT_ERR_BIT = 2;
    localparam int STAT_NETOK_BIT = 3;
    localparam int STAT_SRC_LSB = 4;
    localparam int STAT_LVL_LSB = 8;
    localparam int STAT_TEN_BIT = 16;
    // Clock recovery modes, code 3 is illegal
    localparam logic [1:0] MODE_SYNC = 2'h0;
    localparam logic [1:0] MODE_RTS = 2'h1;
    localparam logic [1:0] MODE_ADAPT = 2'h2;
    // Widths and reset values
    localparam int LVL_W = 6;
    localparam int INC_W = 24;
    localparam int RES_W = 4;
    localparam logic [5:0] THR_LO_RST = 6'h08;
    localparam logic [5:0] THR_HI_RST = 6'h18;
    localparam logic [23:0] INC_NOM = 24'h100000;
    localparam logic [23:0] INC_STEP = 24'h000100;
    // Cycle counts at 20 MHz; RTS period in service and recovered cycles
    localparam logic [7:0] REF_TIMEOUT_CYC = 8'hC8;
    localparam logic [3:0] LOCAL_DIV_CYC = 4'hF;
    localparam logic [7:0] ADJ_PERIOD_CYC = 8'h3F;
    localparam logic [2:0] RTS_PERIOD_CYC = 3'h7;
    typedef enum logic [1:0] {SRC_PRI, SRC_ALT, SRC_LOCAL} src_e;
endpackage

// >>> rtl/ces_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ces_fifo #(
    parameter int W = 8,
    parameter int D = 32,
    parameter int LW = $clog2(D) + 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out,
    output logic [LW-1:0] level_out
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [LW-1:0] cnt_r, cnt_nxt;
    logic push, pop;
    always_comb
    begin
        in_ready_out = (cnt_r != LW'(D));
        out_valid_out = (cnt_r != '0);
        push = in_valid_in && in_ready_out;
        pop = out_valid_out && out_ready_in;
        wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = LW'(cnt_r + LW'(push) - LW'(pop));
        out_data_out = mem[rp_r];
        level_out = cnt_r;
    end
    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem[wp_r] <= in_data_in;
        end
        if (rst_in)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/ces_nco.sv
`timescale 1ns/1ps
`default_nettype none
module ces_nco #(
    parameter int W = 24
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] inc_in,
    output logic tick_out
);
    logic [W:0] acc_r, acc_nxt;
    logic tick_r, tick_nxt;
    // Phase accumulator: carry rate averages the increment over time
    always_comb
    begin
        acc_nxt = {1'b0, acc_r[W-1:0]} + {1'b0, inc_in};
        tick_nxt = acc_nxt[W];
    end
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            acc_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            tick_r <= tick_nxt;
        end
    end
    assign tick_out = tick_r;
endmodule
`default_nettype wire

// >>> rtl/ces_clock_mode_ctrl.sv
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: Three recovery modes per circuit: synchronous, residual time stamp, adaptive.
// R2: Without configuration every circuit runs synchronous.
// R3: Channelised service only allowed while synchronous mode is selected.
// R4: Synchronous mode carries traffic only with network reference present.
// R5: Synchronous transmit clock follows the network reference directly.
// R6: Residual mode only clear channel, and needs network reference.
// R7: Segmenting side measures service clock against reference, emits residuals.
// R8: Reassembly side uses received residuals plus reference to rebuild clock.
// R9: Residual mode gives each circuit its own recovered clock.
// R10: Adaptive mode needs no network reference at all.
// R11: Adaptive mode only for clear channel circuits.
// R12: Adaptive mode tracks average arrival rate, sends at matching rate.
// R13: Adaptive: rising buffer fill speeds up transmit clock.
// R14: Adaptive: draining buffer slows down transmit clock.
// R15: Configuring party picks adaptive only when no reference exists.
// R16: Failed primary reference falls back; primary retaken once restored.
// R17: No usable alternate: local oscillator becomes the reference.
// R18: Channelised plus residual or adaptive is rejected, error flag set.
// R19: Adaptive thresholds programmable, hysteresis band between them.
module ces_clock_mode_ctrl
    import ces_clk_pkg::*;
#(
    parameter int FIFO_DEPTH = 32,
    parameter int DATA_W = 8
) (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    // Avalon-MM slave
    input wire logic [ces_clk_pkg::AVS_AW-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [ces_clk_pkg::AVS_DW-1:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [ces_clk_pkg::AVS_DW-1:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    // Reference and service clock pins
    input wire logic [1:0] NETWORK_REFERENCE_CLOCK_IN,
    input wire logic SERVICE_CLOCK_IN,
    // Constant-rate traffic in
    input wire logic [DATA_W-1:0] RX_DATA_IN,
    input wire logic RX_VALID_IN,
    output logic RX_READY_OUT,
    // Constant-rate traffic out
    output logic [DATA_W-1:0] TX_DATA_OUT,
    output logic TX_VALID_OUT,
    input wire logic TX_READY_IN,
    output logic TX_CLK_OUT,
    // Residual time stamps
    output logic [ces_clk_pkg::RES_W-1:0] RTS_OUT,
    output logic RTS_VALID_OUT,
    input wire logic [ces_clk_pkg::RES_W-1:0] RTS_RX_IN,
    input wire logic RTS_RX_VALID_IN
);
    import ces_clk_pkg::*;

    function automatic logic [1:0] src_code(input src_e s);
        src_code = (s == SRC_PRI) ? 2'h0 : (s == SRC_ALT) ? 2'h1 : 2'h2;
    endfunction

    // Pin synchronisers
    logic [1:0] ref_s1_r, ref_s2_r, ref_s3_r;
    logic svc_s1_r, svc_s2_r, svc_s3_r;
    logic [1:0] ref_edge, ref_ok;
    logic svc_edge;
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            ref_s1_r <= 2'h0;
            ref_s2_r <= 2'h0;
            ref_s3_r <= 2'h0;
            svc_s1_r <= 1'b0;
            svc_s2_r <= 1'b0;
            svc_s3_r <= 1'b0;
        end
        else
        begin
            ref_s1_r <= NETWORK_REFERENCE_CLOCK_IN;
            ref_s2_r <= ref_s1_r;
            ref_s3_r <= ref_s2_r;
            svc_s1_r <= SERVICE_CLOCK_IN;
            svc_s2_r <= svc_s1_r;
            svc_s3_r <= svc_s2_r;
        end
    end
    assign ref_edge = ref_s2_r & ~ref_s3_r;
    assign svc_edge = svc_s2_r & ~svc_s3_r;

    // Loss-of-reference watchdog per source
    for (genvar i = 0; i < 2; i++)
    begin : g_watch
        logic [7:0] tmo_r, tmo_nxt;
        always_comb
        begin
            if (ref_edge[i])
            begin
                tmo_nxt = REF_TIMEOUT_CYC;
            end
            else
            begin
                tmo_nxt = (tmo_r != 8'h00) ? 8'(tmo_r - 8'h01) : tmo_r;
            end
        end
        always_ff @(posedge SYS_CLK_IN)
        begin
            if (SYS_RST_IN)
            begin
                tmo_r <= 8'h00;
            end
            else
            begin
                tmo_r <= tmo_nxt;
            end
        end
        assign ref_ok[i] = (tmo_r != 8'h00);
    end

    // Register file state
    logic [1:0] mode_r, mode_nxt;
    logic chan_r, chan_nxt, alt_en_r, alt_en_nxt, err_r, err_nxt;
    logic [LVL_W-1:0] lo_r, lo_nxt, hi_r, hi_nxt;
    logic wait_r, wait_nxt, cfg_seen_r, cfg_seen_nxt;
    logic [AVS_DW-1:0] rdata_r, rdata_nxt;
    logic req, wr_go, ctrl_wr, ctrl_bad;
    logic [1:0] wr_mode;

    // Reference selection and clocking state
    src_e src_r, src_nxt;
    logic [3:0] loc_cnt_r, loc_cnt_nxt;
    logic loc_tick, sel_pulse, net_ok;
    logic [LVL_W-1:0] level;
    logic [INC_W-1:0] inc_r, inc_nxt;
    logic [RES_W-1:0] rts_r, rts_nxt, ref_mod_r, ref_mod_nxt, loc_res_r, loc_res_nxt;
    logic rts_valid_r, rts_valid_nxt;
    logic [2:0] svc_cnt_r, svc_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
    logic [7:0] adj_cnt_r, adj_cnt_nxt;
    logic adj_tick, nco_tick;
    logic [RES_W-1:0] res_diff;

    assign req = AVS_READ_IN || AVS_WRITE_IN;
    assign wr_go = AVS_WRITE_IN && !wait_r;
    assign ctrl_wr = wr_go && (AVS_ADDRESS_IN == REG_CTRL) && AVS_BYTEENABLE_IN[0];
    assign wr_mode = AVS_WRITEDATA_IN[CTRL_MODE_LSB +: 2];
    // Mode 3 is illegal; channelised needs synchronous mode
    assign ctrl_bad = (wr_mode == 2'h3) ||
        (AVS_WRITEDATA_IN[CTRL_CHAN_BIT] && (wr_mode != MODE_SYNC)); // [R1] [R3] [R6] [R11]

    always_comb
    begin
        mode_nxt = mode_r;
        chan_nxt = chan_r;
        alt_en_nxt = alt_en_r;
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        cfg_seen_nxt = cfg_seen_r || ctrl_wr;
        // One wait cycle, then the request is answered
        wait_nxt = !(req && wait_r);
        rdata_nxt = rdata_r;
        err_nxt = err_r;
        if (ctrl_wr)
        begin
            alt_en_nxt = AVS_WRITEDATA_IN[CTRL_ALT_BIT];
            if (!ctrl_bad)
            begin
                mode_nxt = wr_mode;
                chan_nxt = AVS_WRITEDATA_IN[CTRL_CHAN_BIT];
            end
        end
        if (wr_go && (AVS_ADDRESS_IN == REG_THRESH))
        begin
            if (AVS_BYTEENABLE_IN[0])
            begin
                lo_nxt = AVS_WRITEDATA_IN[THR_LO_LSB +: LVL_W]; // [R19]
            end
            if (AVS_BYTEENABLE_IN[1])
            begin
                hi_nxt = AVS_WRITEDATA_IN[THR_HI_LSB +: LVL_W]; // [R19]
            end
        end
        if (wr_go && (AVS_ADDRESS_IN == REG_STATUS) && AVS_BYTEENABLE_IN[0]
            && AVS_WRITEDATA_IN[STAT_ERR_BIT])
        begin
            err_nxt = 1'b0;
        end
        // Setting wins over a clear in the same cycle
        if (ctrl_wr && ctrl_bad)
        begin
            err_nxt = 1'b1; // [R18]
        end
        if (req && wait_r)
        begin
            rdata_nxt = '0;
            unique case (AVS_ADDRESS_IN)
                REG_CTRL: rdata_nxt[3:0] = {alt_en_r, chan_r, mode_r};
                REG_THRESH:
                begin
                    rdata_nxt[THR_LO_LSB +: LVL_W] = lo_r;
                    rdata_nxt[THR_HI_LSB +: LVL_W] = hi_r;
                end
                REG_STATUS:
                begin
                    rdata_nxt[1:0] = mode_r;
                    rdata_nxt[STAT_ERR_BIT] = err_r;
                    rdata_nxt[STAT_NETOK_BIT] = net_ok;
                    rdata_nxt[STAT_SRC_LSB +: 2] = src_code(src_r);
                    rdata_nxt[STAT_LVL_LSB +: LVL_W] = level;
                    rdata_nxt[STAT_TEN_BIT] = RX_READY_OUT;
                end
                REG_INC: rdata_nxt[INC_W-1:0] = inc_r;
                REG_RTS: rdata_nxt[RES_W-1:0] = rts_r;
                default: rdata_nxt = '0;
            endcase
        end
    end
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            mode_r <= MODE_SYNC; // [R2]
            chan_r <= 1'b0;
            alt_en_r <= 1'b0;
            lo_r <= THR_LO_RST;
            hi_r <= THR_HI_RST;
            err_r <= 1'b0;
            wait_r <= 1'b1;
            rdata_r <= '0;
            cfg_seen_r <= 1'b0;
        end
        else
        begin
            mode_r <= mode_nxt;
            chan_r <= chan_nxt;
            alt_en_r <= alt_en_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            err_r <= err_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            cfg_seen_r <= cfg_seen_nxt;
        end
    end
    assign AVS_READDATA_OUT = rdata_r;
    assign AVS_WAITREQUEST_OUT = wait_r;

    // Reference selection, local oscillator, residuals, rate steering
    assign net_ok = (src_r != SRC_LOCAL);
    assign loc_tick = (loc_cnt_r == LOCAL_DIV_CYC);
    assign adj_tick = (adj_cnt_r == ADJ_PERIOD_CYC);
    assign res_diff = RES_W'(RTS_RX_IN - loc_res_r);
    always_comb
    begin
        if (ref_ok[0])
        begin
            src_nxt = SRC_PRI; // [R16]
        end
        else if (alt_en_r && ref_ok[1])
        begin
            src_nxt = SRC_ALT; // [R16]
        end
        else
        begin
            src_nxt = SRC_LOCAL; // [R17]
        end
        unique case (src_r)
            SRC_PRI: sel_pulse = ref_edge[0];
            SRC_ALT: sel_pulse = ref_edge[1];
            default: sel_pulse = loc_tick;
        endcase
        loc_cnt_nxt = loc_tick ? 4'h0 : 4'(loc_cnt_r + 4'h1);
        adj_cnt_nxt = adj_tick ? 8'h00 : 8'(adj_cnt_r + 8'h01);
        ref_mod_nxt = sel_pulse ? RES_W'(ref_mod_r + 1'b1) : ref_mod_r;
        // Segmenting side: sample reference phase every N service cycles
        svc_cnt_nxt = svc_cnt_r;
        rts_nxt = rts_r;
        rts_valid_nxt = 1'b0;
        if (svc_edge && (mode_r == MODE_RTS))
        begin
            svc_cnt_nxt = 3'(svc_cnt_r + 3'h1);
            if (svc_cnt_r == RTS_PERIOD_CYC)
            begin
                rts_nxt = ref_mod_r; // [R7]
                rts_valid_nxt = 1'b1; // [R7]
            end
        end
        // Reassembly side: local residual over N recovered cycles
        tx_cnt_nxt = tx_cnt_r;
        loc_res_nxt = loc_res_r;
        if (nco_tick)
        begin
            tx_cnt_nxt = 3'(tx_cnt_r + 3'h1);
            if (tx_cnt_r == RTS_PERIOD_CYC)
            begin
                loc_res_nxt = ref_mod_r;
            end
        end
        inc_nxt = inc_r;
        if ((mode_r == MODE_RTS) && RTS_RX_VALID_IN && (res_diff != '0))
        begin
            // More reference edges at the source means our copy runs fast
            if (res_diff[RES_W-1])
            begin
                inc_nxt = INC_W'(inc_r + INC_STEP); // [R8]
            end
            else
            begin
                inc_nxt = INC_W'(inc_r - INC_STEP); // [R8]
            end
        end
        else if ((mode_r == MODE_ADAPT) && adj_tick)
        begin
            // Band between thresholds holds the rate, avoids hunting
            if (level > hi_r && inc_r <= INC_W'(~INC_STEP))
            begin
                inc_nxt = INC_W'(inc_r + INC_STEP); // [R13] [R12]
            end
            else if (level < lo_r && inc_r > INC_STEP)
            begin
                inc_nxt = INC_W'(inc_r - INC_STEP); // [R14] [R12]
            end
        end
    end
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            src_r <= SRC_LOCAL;
            loc_cnt_r <= 4'h0;
            adj_cnt_r <= 8'h00;
            ref_mod_r <= '0;
            svc_cnt_r <= 3'h0;
            tx_cnt_r <= 3'h0;
            rts_r <= '0;
            rts_valid_r <= 1'b0;
            loc_res_r <= '0;
            inc_r <= INC_NOM;
        end
        else
        begin
            src_r <= src_nxt;
            loc_cnt_r <= loc_cnt_nxt;
            adj_cnt_r <= adj_cnt_nxt;
            ref_mod_r <= ref_mod_nxt;
            svc_cnt_r <= svc_cnt_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            rts_r <= rts_nxt;
            rts_valid_r <= rts_valid_nxt;
            loc_res_r <= loc_res_nxt;
            inc_r <= inc_nxt;
        end
    end
    assign RTS_OUT = rts_r;
    assign RTS_VALID_OUT = rts_valid_r;

    // This instance is one circuit with a private recovered clock
    ces_nco #(.W(INC_W)) u_nco (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .inc_in(inc_r),
        .tick_out(nco_tick)
    ); // [R9] [R12]

    // Traffic path
    logic f_in_ready, f_out_valid, pop, tx_tick;
    logic [DATA_W-1:0] f_data;
    logic rx_ready_r, rx_ready_nxt, tx_valid_r, tx_valid_nxt, tx_clk_r, tx_clk_nxt;
    logic [DATA_W-1:0] tx_data_r, tx_data_nxt;
    logic traffic_en;
    // Synchronous locks to the selected reference; others to the NCO
    assign tx_tick = (mode_r == MODE_SYNC) ? sel_pulse : nco_tick; // [R5]
    // Adaptive needs no reference; the other two stall without one
    assign traffic_en = (mode_r == MODE_ADAPT) || net_ok; // [R4] [R6] [R10]
    assign pop = tx_tick && f_out_valid && TX_READY_IN;
    ces_fifo #(.W(DATA_W), .D(FIFO_DEPTH), .LW(LVL_W)) u_fifo (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .in_valid_in(RX_VALID_IN && rx_ready_r),
        .in_ready_out(f_in_ready),
        .in_data_in(RX_DATA_IN),
        .out_valid_out(f_out_valid),
        .out_ready_in(pop),
        .out_data_out(f_data),
        .level_out(level)
    );
    always_comb
    begin
        // Registered ready keeps one slot spare for the in-flight push
        rx_ready_nxt = traffic_en && f_in_ready &&
            (level < LVL_W'(FIFO_DEPTH - 1)); // [R4]
        tx_valid_nxt = pop;
        tx_data_nxt = pop ? f_data : tx_data_r;
        tx_clk_nxt = tx_tick ? !tx_clk_r : tx_clk_r;
    end
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            rx_ready_r <= 1'b0;
            tx_valid_r <= 1'b0;
            tx_data_r <= '0;
            tx_clk_r <= 1'b0;
        end
        else
        begin
            rx_ready_r <= rx_ready_nxt;
            tx_valid_r <= tx_valid_nxt;
            tx_data_r <= tx_data_nxt;
            tx_clk_r <= tx_clk_nxt;
        end
    end
    assign RX_READY_OUT = rx_ready_r;
    assign TX_VALID_OUT = tx_valid_r;
    assign TX_DATA_OUT = tx_data_r;
    assign TX_CLK_OUT = tx_clk_r;

    // Checks
    sequence s_bad_cfg;
        ctrl_wr && ctrl_bad;
    endsequence
    sequence s_period_end;
        svc_edge && (mode_r == MODE_RTS) && (svc_cnt_r == RTS_PERIOD_CYC);
    endsequence
    property p_default_sync;
        @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        !cfg_seen_r |-> (mode_r == MODE_SYNC);
    endproperty
    a_default_sync: assert property (p_default_sync) // [R2]
        else $error("mode left synchronous without configuration");
    property p_chan_sync;
        @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        chan_r |-> (mode_r == MODE_SYNC);
    endproperty
    a_chan_sync: assert property (p_chan_sync) // [R3]
        else $error("channelised service outside synchronous mode");
    property p_reject;
        @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        s_bad_cfg |=> err_r && (mode_r == $past(mode_r)) && (chan_r == $past(chan_r));
    endproperty
    a_reject: assert property (p_reject) // [R18]
        else $error("bad configuration was applied or not flagged");
    property p_no_ref_stall;
        @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (mode_r != MODE_ADAPT) && !net_ok |=> !RX_READY_OUT;
    endproperty
    a_no_ref_stall: assert property (p_no_ref_stall) // [R4]
        else $error("traffic accepted without network reference");
    property p_sync_tick;
        @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (mode_r == MODE_SYNC) && sel_pulse ##0 !ctrl_wr |=> (TX_CLK_OUT != $past(TX_CLK_OUT));
    endproperty
    a_sync_tick: assert property (p_sync_tick) // [R5]
        else $error("transmit clock did not follow reference");
    property p_rts_emit;
        @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        s_period_end |=> RTS_VALID_OUT && (RTS_OUT == $past(ref_mod_r));
    endproperty
    a_rts_emit: assert property (p_rts_emit) // [R7]
        else $error("residual not emitted at period end");
    property p_fallback;
        @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        ref_ok[0] |=> (src_r == SRC_PRI);
    endproperty
    a_fallback: assert property (p_fallback) // [R16]
        else $error("primary reference not retaken");
    property p_local;
        @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        !ref_ok[0] && !(alt_en_r && ref_ok[1]) |=> (src_r == SRC_LOCAL);
    endproperty
    a_local: assert property (p_local) // [R17]
        else $error("local oscillator not selected");
    property p_speed_up;
        @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (mode_r == MODE_ADAPT) && adj_tick && (level > hi_r) && (inc_r < INC_W'(INC_NOM << 1))
        |=> (inc_r == INC_W'($past(inc_r) + INC_STEP));
    endproperty
    a_speed_up: assert property (p_speed_up) // [R13]
        else $error("no speed-up on high fill");
    property p_slow_down;
        @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (mode_r == MODE_ADAPT) && adj_tick && (level < lo_r) && (inc_r > INC_STEP)
        |=> (inc_r == INC_W'($past(inc_r) - INC_STEP));
    endproperty
    a_slow_down: assert property (p_slow_down) // [R14]
        else $error("no slow-down on low fill");
    property p_hold_band;
        @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (mode_r == MODE_ADAPT) && (level >= lo_r) && (level <= hi_r) |=> $stable(inc_r);
    endproperty
    a_hold_band: assert property (p_hold_band) // [R19]
        else $error("rate moved inside hysteresis band");
    property p_adapt_free;
        @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (mode_r == MODE_ADAPT) && f_in_ready && (level < 6'h1E) |=> RX_READY_OUT;
    endproperty
    a_adapt_free: assert property (p_adapt_free) // [R10]
        else $error("adaptive mode stalled on reference");
endmodule
`default_nettype wire

// >>> testbench/ces_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module ces_far_end (
    // Clock
    input wire logic clk_in,
    // Far side
    input wire logic ref_on_in,
    output logic [1:0] ref_out,
    output logic svc_out
);
    logic [3:0] div_r = 4'h0;
    always_ff @(posedge clk_in)
        div_r <= div_r + 4'h1;
    // No alternate wired, so a lost primary must fall to local
    assign ref_out = {1'b0, ref_on_in & div_r[3]};
    assign svc_out = div_r[2];
endmodule
`default_nettype wire

// >>> testbench/ces_clock_recovery_mode_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module ces_clock_recovery_mode_ctrl_test;
    import ces_clk_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    logic [1:0] nref;
    logic svc;
    logic ref_on = 1'b0;
    logic [7:0] rx_d = 8'h00;
    logic rx_v = 1'b0;
    logic rx_rdy;
    logic [7:0] tx_d;
    logic tx_v;
    logic tx_rdy = 1'b0;
    logic tx_clk;
    logic rts_v;
    logic [3:0] rts;
    logic [31:0] q;
    logic [31:0] inc_full;
    int bad_count = 0;
    int n_checks = 0;
    always #25 clk = ~clk;
    ces_far_end ces_far_end_i (.clk_in(clk), .ref_on_in(ref_on), .ref_out(nref), .svc_out(svc));
    ces_clock_mode_ctrl ces_clock_mode_ctrl_i (.SYS_CLK_IN(clk), .SYS_RST_IN(rst),
        .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
        .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq),
        .NETWORK_REFERENCE_CLOCK_IN(nref), .SERVICE_CLOCK_IN(svc), .RX_DATA_IN(rx_d),
        .RX_VALID_IN(rx_v), .RX_READY_OUT(rx_rdy), .TX_DATA_OUT(tx_d), .TX_VALID_OUT(tx_v),
        .TX_READY_IN(tx_rdy), .TX_CLK_OUT(tx_clk), .RTS_OUT(rts), .RTS_VALID_OUT(rts_v),
        .RTS_RX_IN(4'h0), .RTS_RX_VALID_IN(1'b0));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        chk(n < 50, 1'b1);
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    task automatic t_reset;
        rdchk(REG_CTRL, 32'hF, 32'h0);
        rdchk(REG_THRESH, 32'h3F3F, 32'h1808);
        rdchk(REG_INC, 32'hFFFFFF, 32'h100000);
        rdchk(5'h14, 32'hFFFFFFFF, 32'h0);
    endtask
    task automatic t_config;
        logic [31:0] bad_cfg [3] = '{32'h5, 32'h6, 32'h3};
        for (int m = 0; m < 3; m++)
        begin
            bus(1'b1, REG_CTRL, m);
            rdchk(REG_STATUS, 32'h7, m);
        end
        foreach (bad_cfg[i])
        begin
            bus(1'b1, REG_CTRL, bad_cfg[i]);
            rdchk(REG_STATUS, 32'h7, 32'h6);
            bus(1'b1, REG_STATUS, 32'h4);
        end
        bus(1'b1, REG_CTRL, 32'h4);
        rdchk(REG_CTRL, 32'hF, 32'h4);
        bus(1'b1, REG_CTRL, 32'h0);
    endtask
    task automatic t_sync;
        int k = 0;
        logic p;
        rdchk(REG_STATUS, 32'h10008, 32'h0);
        ref_on <= 1'b1;
        repeat (60) @(posedge clk);
        rdchk(REG_STATUS, 32'h10038, 32'h10008);
        // Reference rises every 16 cycles, one toggle each
        p = tx_clk;
        repeat (160)
        begin
            @(posedge clk);
            k += int'(tx_clk !== p);
            p = tx_clk;
        end
        chk(k, 10);
        ref_on <= 1'b0;
        repeat (260) @(posedge clk);
        rdchk(REG_STATUS, 32'h10030, 32'h20);
    endtask
    task automatic t_adapt;
        int n;
        // Adaptive picked only while reference is absent
        bus(1'b1, REG_CTRL, 32'h2);
        rdchk(REG_STATUS, 32'h10000, 32'h10000);
        rx_v <= 1'b1;
        repeat (60)
        begin
            @(posedge clk);
            if (rx_rdy === 1'b1)
                rx_d <= rx_d + 8'h01;
        end
        rx_v <= 1'b0;
        // Registered ready lets the in-flight word take the last slot
        rdchk(REG_STATUS, 32'h13F00, 32'h2000);
        repeat (140) @(posedge clk);
        bus(1'b0, REG_INC, 32'h0);
        inc_full = q;
        chk(inc_full[23:0] > INC_NOM, 1'b1);
        tx_rdy <= 1'b1;
        n = 0;
        repeat (3000)
        begin
            @(posedge clk);
            if (tx_v === 1'b1)
            begin
                chk({24'h0, tx_d}, n);
                n++;
            end
        end
        chk(n, 32);
        bus(1'b0, REG_INC, 32'h0);
        chk(q[23:0] < inc_full[23:0], 1'b1);
    endtask
    task automatic t_rts;
        int k = 0;
        logic [3:0] p;
        bus(1'b1, REG_CTRL, 32'h1);
        repeat (10) @(posedge clk);
        repeat (640)
        begin
            @(posedge clk);
            if (rts_v === 1'b1)
            begin
                // Eight service periods span four local ticks
                if (k > 0)
                    chk(rts, 4'(p + 4'h4));
                p = rts;
                k++;
            end
        end
        chk(k, 10);
    endtask
    task automatic end_sim;
        $display("checks %0d bad %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_config();
        t_sync();
        t_adapt();
        t_rts();
        end_sim();
    end
    initial
    begin
        #1000000;
        bad_count++;
        end_sim();
    end
endmodule
`default_nettype wire
